// ==== shared/csel_map.svh ====
// Purpose: Offsets, reset values, field positions and timing counts
// Assumes: 200 MHz reference clock
// Notes:   Register index equals address on the register port
`ifndef CSEL_MAP_SVH
`define CSEL_MAP_SVH

`define CSEL_A_CMD        4'h0
`define CSEL_A_AIN1_TYPE  4'h1
`define CSEL_A_AIN2_TYPE  4'h2
`define CSEL_A_AIN2_FUNC  4'h3
`define CSEL_A_DIN1_FUNC  4'h4
`define CSEL_A_DIN2_FUNC  4'h5
`define CSEL_A_CYCLE      4'h6
`define CSEL_A_DELAY      4'h7
`define CSEL_A_BAKE_OFF   4'h8
`define CSEL_A_BAKE_RAMP  4'h9
`define CSEL_A_BAKE_CUR   4'ha
`define CSEL_A_PORT2      4'hb
`define CSEL_A_STATUS     4'hc
`define CSEL_A_AIN1_VAL   4'hd
`define CSEL_A_AIN2_VAL   4'he
`define CSEL_A_AUX_VOLT   4'hf

`define CSEL_CMD_SP_BIT   1
`define CSEL_CMD_EN_BIT   2
`define CSEL_CMD_IL_BIT   4
`define CSEL_CMD_MASK     16'h0016

`define CSEL_CYCLE_RST    8'h1e
`define CSEL_DELAY_RST    7'h3c
`define CSEL_DELAY_MAX    7'h5a
`define CSEL_MIN_RST      11'h001
`define CSEL_MIN_MAX      11'h7cf
`define CSEL_CUR_RST      14'h0000
`define CSEL_CUR_MAX      14'h270f
`define CSEL_PCT_MAX      10'h3e8

`define CSEL_CLK_PERIOD_PS 5000
`define CSEL_TICK_TIME_US  1000
`define CSEL_STEP_MS       50
`define CSEL_MINUTE_MS     60000

`endif

// ==== shared/csel_pkg.sv ====
// Purpose: Types for the control source select block
// Assumes: Nothing beyond the map header
// Notes:   Enum codes follow the stored register values
`default_nettype none
package csel_pkg;

    typedef enum logic [2:0] {
        DIN_ENABLE, DIN_VOLT_FB, DIN_LOC_REM, DIN_PHASE,
        DIN_SP_SEL, DIN_LOGGING, DIN_BAKEOUT
    } csel_din_func_t;

    typedef enum logic [1:0] {
        AIN_RSVD, AIN_VOLT_POT, AIN_4_20MA, AIN_0_20MA
    } csel_ain_type_t;

    typedef enum logic [1:0] {
        AIN2_ILIMIT, AIN2_FEEDBACK, AIN2_SET_POINT
    } csel_ain2_func_t;

    typedef struct packed {
        logic out_en;
        logic sp_local;
        logic sp_ain2;
        logic ilim_local;
        logic phase_angle;
        logic volt_fb;
        logic log_en;
        logic bake_en;
    } csel_ctrl_t;

endpackage
`default_nettype wire

// ==== rtl/csel_sync.sv ====
// Purpose: Two-stage synchroniser, one stage pair per bit
// Assumes: Inputs asynchronous to REF_CLK_I
// Notes:   First stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module csel_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= d_i[g];
                    sync_reg <= meta_reg;
                end
            end
            assign q_o[g] = sync_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== rtl/csel_top.sv ====
// Purpose: Command word, input function selection and firing parameters
// Assumes: Register port driven by the serial protocol engine, same clock
// Notes:   Out-of-range writes leave the register unchanged; PORT2 stores bit 0 and the command word is masked
`timescale 1ns/1ps
`default_nettype none
`include "csel_map.svh"
module csel_top #(
    parameter int MS_CYCLES = `CSEL_TICK_TIME_US * 1000 * 1000 / `CSEL_CLK_PERIOD_PS
) (
    input  wire logic              REF_CLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    input  wire logic [3:0]        REG_ADDR_I,
    input  wire logic [15:0]       REG_WDATA_I,
    output logic      [15:0]       REG_RDATA_O,
    output logic                   REG_RVALID_O,
    input  wire logic [1:0]        DIN_I,
    input  wire logic [9:0]        AIN1_VAL_I,
    input  wire logic [9:0]        AIN2_VAL_I,
    input  wire logic [9:0]        AUX_VOLT_I,
    output csel_pkg::csel_ctrl_t   CTRL_O,
    output csel_pkg::csel_ain2_func_t AIN2_FUNC_O,
    output csel_pkg::csel_ain_type_t  AIN1_TYPE_O,
    output csel_pkg::csel_ain_type_t  AIN2_TYPE_O,
    output logic [6:0]             DELAY_DEG_O,
    output logic [13:0]            BAKE_CUR_O,
    output logic                   CYCLE_START_O,
    output logic                   BAKE_REQ_O,
    output logic                   BAKE_DONE_O
);
    localparam int MSW = $clog2(MS_CYCLES);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0]                     cmd_reg;
    csel_pkg::csel_ain_type_t        ain1_type_reg;
    csel_pkg::csel_ain_type_t        ain2_type_reg;
    csel_pkg::csel_ain2_func_t       ain2_func_reg;
    csel_pkg::csel_din_func_t        din_func_reg [2];
    logic [7:0]                      cycle_reg;
    logic [6:0]                      delay_reg;
    logic [10:0]                     bake_off_reg;
    logic [10:0]                     bake_ramp_reg;
    logic [13:0]                     bake_cur_reg;
    logic                            port2_rw_reg;
    csel_pkg::csel_ctrl_t            ctrl_reg;
    csel_pkg::csel_ctrl_t            ctrl_next;
    logic [1:0]                      din_sync;

    csel_sync #(
        .W (2)
    ) u_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESET_N_I),
        .d_i     (DIN_I),
        .q_o     (din_sync)
    );

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire wr_cmd   = REG_WR_I && REG_ADDR_I == `CSEL_A_CMD;
    wire wr_a1t   = REG_WR_I && REG_ADDR_I == `CSEL_A_AIN1_TYPE
                    && REG_WDATA_I[15:2] == 14'h0 && REG_WDATA_I[1:0] != 2'h0;
    wire wr_a2t   = REG_WR_I && REG_ADDR_I == `CSEL_A_AIN2_TYPE
                    && REG_WDATA_I[15:2] == 14'h0 && REG_WDATA_I[1:0] != 2'h0;
    wire wr_a2f   = REG_WR_I && REG_ADDR_I == `CSEL_A_AIN2_FUNC
                    && REG_WDATA_I < 16'h0003;
    wire fn_ok    = REG_WDATA_I < 16'h0007;
    wire wr_d1f   = REG_WR_I && REG_ADDR_I == `CSEL_A_DIN1_FUNC && fn_ok;
    wire wr_d2f   = REG_WR_I && REG_ADDR_I == `CSEL_A_DIN2_FUNC && fn_ok;
    wire wr_cyc   = REG_WR_I && REG_ADDR_I == `CSEL_A_CYCLE
                    && REG_WDATA_I[15:8] == 8'h0;
    wire wr_dly   = REG_WR_I && REG_ADDR_I == `CSEL_A_DELAY
                    && REG_WDATA_I <= {9'h0, `CSEL_DELAY_MAX};
    wire min_ok   = REG_WDATA_I != 16'h0 && REG_WDATA_I <= {5'h0, `CSEL_MIN_MAX};
    wire wr_boff  = REG_WR_I && REG_ADDR_I == `CSEL_A_BAKE_OFF && min_ok;
    wire wr_bramp = REG_WR_I && REG_ADDR_I == `CSEL_A_BAKE_RAMP && min_ok;
    wire wr_bcur  = REG_WR_I && REG_ADDR_I == `CSEL_A_BAKE_CUR
                    && REG_WDATA_I <= {2'h0, `CSEL_CUR_MAX};
    wire wr_p2    = REG_WR_I && REG_ADDR_I == `CSEL_A_PORT2;

    // Command bits other than 1, 2 and 4 have no function
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cmd_reg <= 16'h0000;
        end else if (wr_cmd) begin
            cmd_reg <= REG_WDATA_I & `CSEL_CMD_MASK;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ain1_type_reg <= csel_pkg::AIN_VOLT_POT;
            ain2_type_reg <= csel_pkg::AIN_VOLT_POT;
        end else begin
            if (wr_a1t) ain1_type_reg <= csel_pkg::csel_ain_type_t'(REG_WDATA_I[1:0]);
            if (wr_a2t) ain2_type_reg <= csel_pkg::csel_ain_type_t'(REG_WDATA_I[1:0]);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            din_func_reg[0] <= csel_pkg::DIN_VOLT_FB;
            din_func_reg[1] <= csel_pkg::DIN_ENABLE;
            ain2_func_reg   <= csel_pkg::AIN2_ILIMIT;
        end else begin
            if (wr_d1f) din_func_reg[0] <= csel_pkg::csel_din_func_t'(REG_WDATA_I[2:0]);
            if (wr_d2f) din_func_reg[1] <= csel_pkg::csel_din_func_t'(REG_WDATA_I[2:0]);
            if (wr_a2f) ain2_func_reg <= csel_pkg::csel_ain2_func_t'(REG_WDATA_I[1:0]);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cycle_reg     <= `CSEL_CYCLE_RST;
            delay_reg     <= `CSEL_DELAY_RST;
            bake_off_reg  <= `CSEL_MIN_RST;
            bake_ramp_reg <= `CSEL_MIN_RST;
            bake_cur_reg  <= `CSEL_CUR_RST;
            port2_rw_reg  <= 1'b0;
        end else begin
            if (wr_cyc)   cycle_reg     <= REG_WDATA_I[7:0];
            if (wr_dly)   delay_reg     <= REG_WDATA_I[6:0];
            if (wr_boff)  bake_off_reg  <= REG_WDATA_I[10:0];
            if (wr_bramp) bake_ramp_reg <= REG_WDATA_I[10:0];
            if (wr_bcur)  bake_cur_reg  <= REG_WDATA_I[13:0];
            if (wr_p2)    port2_rw_reg  <= REG_WDATA_I[0];
        end
    end

    // ----------------------------------------
    // Function resolution
    // ----------------------------------------
    logic [6:0] fn_asg;
    logic [6:0] fn_on;
    genvar f;
    generate
        for (f = 0; f < 7; f++) begin : g_fn
            wire h0 = din_func_reg[0] == csel_pkg::csel_din_func_t'(f);
            wire h1 = din_func_reg[1] == csel_pkg::csel_din_func_t'(f);
            assign fn_asg[f] = h0 | h1;
            assign fn_on[f]  = (h0 & din_sync[0]) | (h1 & din_sync[1]);
        end
    endgenerate

    wire cmd_sp = cmd_reg[`CSEL_CMD_SP_BIT];
    wire cmd_en = cmd_reg[`CSEL_CMD_EN_BIT];
    wire en_asg = fn_asg[csel_pkg::DIN_ENABLE];
    wire en_on  = fn_on[csel_pkg::DIN_ENABLE];
    wire lr_asg = fn_asg[csel_pkg::DIN_LOC_REM];
    wire lr_on  = fn_on[csel_pkg::DIN_LOC_REM];

    wire en_res = port2_rw_reg ? (cmd_en & (~en_asg | en_on))
                               : (en_asg ? en_on : cmd_en);
    wire sp_res = (port2_rw_reg | ~lr_asg) ? cmd_sp : lr_on;

    always_comb begin
        ctrl_next             = '0;
        ctrl_next.out_en      = en_res;
        ctrl_next.sp_local    = sp_res;
        ctrl_next.sp_ain2     = fn_on[csel_pkg::DIN_SP_SEL];
        ctrl_next.ilim_local  = cmd_reg[`CSEL_CMD_IL_BIT];
        ctrl_next.phase_angle = fn_on[csel_pkg::DIN_PHASE];
        ctrl_next.volt_fb     = fn_on[csel_pkg::DIN_VOLT_FB];
        ctrl_next.log_en      = fn_on[csel_pkg::DIN_LOGGING];
        ctrl_next.bake_en     = fn_on[csel_pkg::DIN_BAKEOUT];
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    // One shared millisecond prescaler keeps all slow timers cheap
    logic [MSW-1:0] ms_cnt_reg;
    logic [5:0]     step_cnt_reg;
    logic [15:0]    min_cnt_reg;
    logic [8:0]     cyc_cnt_reg;
    wire ms_tick   = ms_cnt_reg == MSW'(MS_CYCLES - 1);
    wire step_tick = ms_tick && step_cnt_reg == 6'(`CSEL_STEP_MS - 1);
    wire min_tick  = ms_tick && min_cnt_reg == 16'(`CSEL_MINUTE_MS - 1);
    // period in 50 ms steps; zero gives one step
    wire cyc_done  = step_tick && (cyc_cnt_reg + 9'h001 >= {1'b0, cycle_reg});

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ms_cnt_reg   <= '0;
            step_cnt_reg <= 6'h00;
            min_cnt_reg  <= 16'h0000;
            cyc_cnt_reg  <= 9'h000;
        end else begin
            ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + MSW'(1);
            if (ms_tick) begin
                step_cnt_reg <= step_tick ? 6'h00 : step_cnt_reg + 6'h01;
                min_cnt_reg  <= min_tick ? 16'h0000 : min_cnt_reg + 16'h0001;
            end
            if (cyc_done) begin
                cyc_cnt_reg <= 9'h000;
            end else if (step_tick) begin
                cyc_cnt_reg <= cyc_cnt_reg + 9'h001;
            end
        end
    end

    // ----------------------------------------
    // Bakeout
    // ----------------------------------------
    logic [10:0] off_min_reg;
    logic [10:0] ramp_min_reg;
    logic        bake_req_reg;
    logic        bake_done_reg;
    wire ramp_run  = bake_req_reg & ctrl_reg.out_en & ctrl_reg.bake_en;
    wire ramp_end  = ramp_run && ramp_min_reg >= bake_ramp_reg;
    wire req_set   = ~ctrl_reg.out_en && off_min_reg > bake_off_reg;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            off_min_reg   <= 11'h000;
            ramp_min_reg  <= 11'h000;
            bake_req_reg  <= 1'b0;
            bake_done_reg <= 1'b0;
        end else begin
            if (ctrl_reg.out_en) begin
                off_min_reg <= 11'h000;
            end else if (min_tick && off_min_reg != 11'h7ff) begin
                off_min_reg <= off_min_reg + 11'h001;
            end
            if (!ramp_run) begin
                ramp_min_reg <= 11'h000;
            end else if (min_tick && !ramp_end) begin
                ramp_min_reg <= ramp_min_reg + 11'h001;
            end
            // Set wins over the ramp-end clear
            bake_req_reg  <= req_set | (bake_req_reg & ~ramp_end);
            bake_done_reg <= ramp_end;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // AIN1 and AIN2 readings clamp at 100.0 percent; AUX_VOLT_I is not clamped
    wire [9:0] a1_pct = AIN1_VAL_I > `CSEL_PCT_MAX ? `CSEL_PCT_MAX : AIN1_VAL_I;
    wire [9:0] a2_pct = AIN2_VAL_I > `CSEL_PCT_MAX ? `CSEL_PCT_MAX : AIN2_VAL_I;
    logic [15:0] rd_mux;
    always_comb begin
        unique case (REG_ADDR_I)
            `CSEL_A_CMD:       rd_mux = cmd_reg;
            `CSEL_A_AIN1_TYPE: rd_mux = {14'h0, ain1_type_reg};
            `CSEL_A_AIN2_TYPE: rd_mux = {14'h0, ain2_type_reg};
            `CSEL_A_AIN2_FUNC: rd_mux = {14'h0, ain2_func_reg};
            `CSEL_A_DIN1_FUNC: rd_mux = {13'h0, din_func_reg[0]};
            `CSEL_A_DIN2_FUNC: rd_mux = {13'h0, din_func_reg[1]};
            `CSEL_A_CYCLE:     rd_mux = {8'h0, cycle_reg};
            `CSEL_A_DELAY:     rd_mux = {9'h0, delay_reg};
            `CSEL_A_BAKE_OFF:  rd_mux = {5'h0, bake_off_reg};
            `CSEL_A_BAKE_RAMP: rd_mux = {5'h0, bake_ramp_reg};
            `CSEL_A_BAKE_CUR:  rd_mux = {2'h0, bake_cur_reg};
            `CSEL_A_PORT2:     rd_mux = {15'h0, port2_rw_reg};
            `CSEL_A_STATUS:    rd_mux = {12'h0, bake_req_reg, ctrl_reg.out_en, din_sync};
            `CSEL_A_AIN1_VAL:  rd_mux = {6'h0, a1_pct};
            `CSEL_A_AIN2_VAL:  rd_mux = {6'h0, a2_pct};
            `CSEL_A_AUX_VOLT:  rd_mux = {6'h0, AUX_VOLT_I};
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            REG_RDATA_O  <= 16'h0000;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) REG_RDATA_O <= rd_mux;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // out_en carries the resolved enable; of the other outputs only BAKE_REQ_O, BAKE_DONE_O and the STATUS read data depend on it
    assign CTRL_O        = ctrl_reg;
    assign AIN2_FUNC_O   = ain2_func_reg;
    assign AIN1_TYPE_O   = ain1_type_reg;
    assign AIN2_TYPE_O   = ain2_type_reg;
    assign DELAY_DEG_O   = delay_reg;
    assign BAKE_CUR_O    = bake_cur_reg;
    assign CYCLE_START_O = cyc_done;
    assign BAKE_REQ_O    = bake_req_reg;
    assign BAKE_DONE_O   = bake_done_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    property p_sp_port2;
        port2_rw_reg |=> CTRL_O.sp_local == $past(cmd_reg[1]);
    endproperty
    a_sp_port2: assert property (p_sp_port2) else $error("sp source wrong");
    property p_en_cmd;
        !en_asg && !port2_rw_reg |=> CTRL_O.out_en == $past(cmd_reg[2]);
    endproperty
    a_en_cmd: assert property (p_en_cmd) else $error("cmd enable wrong");
    property p_en_both;
        port2_rw_reg && en_asg |=> CTRL_O.out_en == $past(cmd_en & en_on);
    endproperty
    a_en_both: assert property (p_en_both) else $error("dual enable wrong");
    property p_cmd_mask;
        wr_cmd |=> (cmd_reg & ~`CSEL_CMD_MASK) == 16'h0000;
    endproperty
    a_cmd_mask: assert property (p_cmd_mask) else $error("dead cmd bit set");
    property p_delay_range;
        delay_reg <= `CSEL_DELAY_MAX;
    endproperty
    a_delay_range: assert property (p_delay_range) else $error("delay over 90");
    property p_min_range;
        bake_off_reg != 11'h0 && bake_ramp_reg <= `CSEL_MIN_MAX;
    endproperty
    a_min_range: assert property (p_min_range) else $error("minutes range");
    property p_din_follow;
        $changed(DIN_I[0]) ##1 $stable(DIN_I[0]) [*2] |-> din_sync[0] == DIN_I[0];
    endproperty
    a_din_follow: assert property (p_din_follow) else $error("sync latency");
    property p_phase;
        fn_on[csel_pkg::DIN_PHASE] |=> CTRL_O.phase_angle;
    endproperty
    a_phase: assert property (p_phase) else $error("phase not forced");
    property p_ilim;
        wr_cmd ##1 !wr_cmd |=> CTRL_O.ilim_local == $past(REG_WDATA_I[4], 2);
    endproperty
    a_ilim: assert property (p_ilim) else $error("ilim source wrong");
    property p_cyc_step;
        cyc_done |-> step_tick;
    endproperty
    a_cyc_step: assert property (p_cyc_step) else $error("cycle off step");

    c_en_din: cover property (en_asg && en_on ##1 CTRL_O.out_en);
    c_port2:  cover property (port2_rw_reg && lr_asg && !lr_on && cmd_sp);
    c_bake:   cover property (BAKE_REQ_O ##1 !BAKE_REQ_O);
    c_cycle:  cover property (CYCLE_START_O);
endmodule
`default_nettype wire

// ==== dv/csel_field.sv ====
// Purpose: Field side model driving the two digital inputs
// Assumes: Bench asks for levels on the reference clock
// Notes:   Clean levels only; no contact bounce, so checks stay exact
`timescale 1ns/1ps
`default_nettype none
module csel_field (
    input  wire logic       clk_i,
    input  wire logic [1:0] lvl_i,
    output logic      [1:0] din_o
);
    // Inputs are plain levels, so they are held until the bench asks again
    always @(posedge clk_i) din_o <= lvl_i;
endmodule
`default_nettype wire

// ==== dv/csel_top_tb.sv ====
// Purpose: Register and field input checks for csel_top
// Assumes: MS_CYCLES of 4 keeps the timer checks short
// Notes:   Bakeout minute counts are too long to reach here
`timescale 1ns/1ps
`default_nettype none
module csel_top_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int MS = 4;
    logic        clk, rst_n, wr, rd, rvalid, cyc;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata;
    logic [1:0]  lvl, din;
    logic [9:0]  ain1, ain2, aux;
    logic [7:0]  ctrl;
    logic [6:0]  dly;
    logic [1:0]  a1t, a2t, a2f;
    logic [13:0] bcur;
    logic        breq, bdone;
    int          num_errors, num_checks, n;
    logic [15:0] rst_tab [12] = '{16'h0, 16'h1, 16'h1, 16'h0, 16'h1, 16'h0,
                                  16'h1e, 16'h3c, 16'h1, 16'h1, 16'h0, 16'h0};
    logic [7:0]  fn_tab [7] = '{8'h80, 8'h04, 8'h40, 8'h08, 8'h20, 8'h02, 8'h01};
    csel_field i_csel_field (.clk_i(clk), .lvl_i(lvl), .din_o(din));
    csel_top #(.MS_CYCLES(MS)) i_csel_top (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .DIN_I(din), .AIN1_VAL_I(ain1), .AIN2_VAL_I(ain2),
        .AUX_VOLT_I(aux), .CTRL_O(ctrl), .AIN2_FUNC_O(a2f), .AIN1_TYPE_O(a1t),
        .AIN2_TYPE_O(a2t), .DELAY_DEG_O(dly), .BAKE_CUR_O(bcur), .CYCLE_START_O(cyc),
        .BAKE_REQ_O(breq), .BAKE_DONE_O(bdone));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read answer is registered on the taking edge and checked just after it
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rvalid", 16'h1, {15'h0, rvalid});
        chk("rdata", e, rdata);
    endtask
    // Sync plus register stage; five cycles leaves margin
    task automatic ctrl_is(input logic [7:0] e);
        repeat (5) @(posedge clk);
        #1;
        chk("ctrl", {8'h0, e}, {8'h0, ctrl});
    endtask
    task automatic wait_cyc();
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cyc !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        {wr, rd, addr, wdata, lvl} = '0;
        ain1 = 10'h3e8;
        ain2 = 10'h3e9;
        aux = 10'h3ff;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) rd_reg(4'(i), rst_tab[i]);
        rd_reg(4'hc, 16'h0);
        wr_reg(4'h0, 16'hffff);
        rd_reg(4'h0, 16'h0016);
        ctrl_is(8'h50);
        wr_reg(4'h0, 16'h0);
        ctrl_is(8'h00);
        // Out of range values must leave the register alone
        wr_reg(4'h7, 16'h5b);
        rd_reg(4'h7, 16'h3c);
        wr_reg(4'h7, 16'h5a);
        rd_reg(4'h7, 16'h5a);
        chk("delay", 16'h5a, {9'h0, dly});
        wr_reg(4'h1, 16'h0);
        rd_reg(4'h1, 16'h1);
        wr_reg(4'h1, 16'h2);
        rd_reg(4'h1, 16'h2);
        chk("ain1_type", 16'h2, {14'h0, a1t});
        wr_reg(4'h2, 16'h3);
        rd_reg(4'h2, 16'h3);
        chk("ain2_type", 16'h3, {14'h0, a2t});
        wr_reg(4'h3, 16'h3);
        rd_reg(4'h3, 16'h0);
        wr_reg(4'h3, 16'h2);
        rd_reg(4'h3, 16'h2);
        chk("ain2_func", 16'h2, {14'h0, a2f});
        wr_reg(4'h8, 16'h7d0);
        rd_reg(4'h8, 16'h1);
        wr_reg(4'ha, 16'h2710);
        rd_reg(4'ha, 16'h0);
        wr_reg(4'ha, 16'h270f);
        rd_reg(4'ha, 16'h270f);
        chk("bake_cur", 16'h270f, {2'h0, bcur});
        wr_reg(4'h4, 16'h7);
        rd_reg(4'h4, 16'h1);
        lvl <= 2'b01;
        for (int f = 0; f < 7; f++) begin
            wr_reg(4'h4, 16'(f));
            ctrl_is(fn_tab[f]);
        end
        wr_reg(4'h4, 16'h2);
        lvl <= 2'b11;
        ctrl_is(8'hc0);
        rd_reg(4'hc, 16'h7);
        wr_reg(4'hb, 16'h1);
        ctrl_is(8'h00);
        wr_reg(4'h0, 16'h4);
        ctrl_is(8'h80);
        lvl <= 2'b01;
        ctrl_is(8'h00);
        // No input holds enable now, so command bit 2 rules alone
        wr_reg(4'hb, 16'h0);
        wr_reg(4'h5, 16'h3);
        ctrl_is(8'hc0);
        wr_reg(4'h0, 16'h16);
        ctrl_is(8'hd0);
        wr_reg(4'hd, 16'h0);
        rd_reg(4'hd, 16'h3e8);
        rd_reg(4'he, 16'h3e8);
        rd_reg(4'hf, 16'h3ff);
        wr_reg(4'h6, 16'h2);
        wait_cyc();
        wait_cyc();
        chk("cycle", 16'(2 * 50 * MS), 16'(n));
        // Minute counts are far beyond this run, so no bakeout yet
        chk("bake_req", 16'h0, {15'h0, breq});
        chk("bake_done", 16'h0, {15'h0, bdone});
        finish_test();
    end
endmodule
`default_nettype wire
